// ### pst_pkg.sv
// Shared constants and types for the program stack and table read block.
package pst_pkg;

  // ---------------------------------------------------------------
  // Widths and sizes
  // ---------------------------------------------------------------
  localparam int PST_PC_W    = 10;
  localparam int PST_WORD_W  = 14;
  localparam int PST_DATA_W  = 8;
  localparam int PST_DEPTH   = 4;
  localparam int PST_SP_W    = 2;
  localparam int PST_CNT_W   = 3;
  localparam int PST_MEM_WORDS = 1024;
  localparam int PST_HIGH_W  = PST_WORD_W - PST_DATA_W;

  // ---------------------------------------------------------------
  // Fixed addresses and reset values
  // ---------------------------------------------------------------
  localparam logic [PST_PC_W-1:0]  PST_RESET_VECTOR = 10'h000;
  localparam logic [1:0]           PST_LAST_PAGE    = 2'h3;
  localparam logic [PST_CNT_W-1:0] PST_FULL_COUNT   = 3'h4;
  localparam logic [PST_PC_W-1:0]  PST_PC_STEP      = 10'h001;
  localparam logic [PST_PC_W-1:0]  PST_PC_SKIP      = 10'h002;

  // ---------------------------------------------------------------
  // Status flag positions and decimal adjust figures
  // ---------------------------------------------------------------
  localparam int PST_FLAG_C  = 0;
  localparam int PST_FLAG_AC = 1;
  localparam int PST_FLAG_Z  = 2;
  localparam int PST_FLAG_OV = 3;
  localparam logic [3:0] PST_BCD_MAX = 4'h9;
  localparam logic [3:0] PST_BCD_ADJ = 4'h6;

  // ---------------------------------------------------------------
  // Serial programming frame
  // ---------------------------------------------------------------
  localparam int PST_ICP_CNT_W = 5;
  localparam logic [PST_ICP_CNT_W-1:0] PST_ICP_HDR_BITS   = 5'h0b;
  localparam logic [PST_ICP_CNT_W-1:0] PST_ICP_FRAME_BITS = 5'h19;
  localparam int PST_ICP_SH_W = 25;

  // ---------------------------------------------------------------
  // Commands, operations and states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    PST_CMD_ALU                   = 3'h0,
    PST_CMD_JUMP                  = 3'h1,
    PST_CMD_CALL                  = 3'h2,
    PST_CMD_SUBROUTINE_RETURN     = 3'h3,
    PST_CMD_INTERRUPT_RETURN      = 3'h4,
    PST_CMD_TABLE_READ            = 3'h5,
    PST_CMD_TABLE_READ_LAST_PAGE  = 3'h6
  } pst_cmd_type;

  typedef enum logic [4:0] {
    PST_OP_ADD = 5'h00, PST_OP_ADC = 5'h01, PST_OP_SUB = 5'h02,
    PST_OP_SBC = 5'h03, PST_OP_DECIMAL_ADJUST = 5'h04,
    PST_OP_AND = 5'h05, PST_OP_OR = 5'h06, PST_OP_XOR = 5'h07,
    PST_OP_CPL = 5'h08, PST_OP_RR = 5'h09, PST_OP_RRC = 5'h0a,
    PST_OP_RL = 5'h0b, PST_OP_RLC = 5'h0c, PST_OP_INC = 5'h0d,
    PST_OP_DEC = 5'h0e, PST_OP_SKIP_ZERO = 5'h0f,
    PST_OP_SKIP_NONZERO = 5'h10, PST_OP_INC_SKIP_ZERO = 5'h11,
    PST_OP_DEC_SKIP_ZERO = 5'h12
  } pst_alu_op_type;

  typedef enum logic [1:0] {
    PST_ST_RUN    = 2'b01,
    PST_ST_SECOND = 2'b10
  } pst_state_type;

endpackage

// ### pst_alu.sv
// Eight bit arithmetic and logic unit with status flags and skip decision.
`timescale 1ns/100ps
module pst_alu (
  // Operation select.
  input  pst_pkg::pst_alu_op_type op,
  // Operands and incoming flags.
  input  wire logic [7:0]         a,
  input  wire logic [7:0]         b,
  input  wire logic [3:0]         flags_in,
  // Result, flags and branch decision.
  output logic [7:0]              res,
  output logic [3:0]              flags_out,
  output logic                    skip
);
  import pst_pkg::*;

  // Computes the result and updates carry, borrow, zero and overflow.
  always_comb begin
    logic [8:0] s9;
    logic [4:0] s5;
    logic [7:0] adj;
    logic       cy;
    s9 = 9'h000;
    s5 = 5'h00;
    adj = 8'h00;
    cy = 1'b0;
    res = a;
    flags_out = flags_in;
    skip = 1'b0;
    case (op)
      PST_OP_ADD, PST_OP_ADC: begin
        cy = (op == PST_OP_ADC) ? flags_in[PST_FLAG_C] : 1'b0;
        s9 = {1'b0, a} + {1'b0, b} + {8'h00, cy};
        s5 = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cy};
        res = s9[7:0];
        flags_out[PST_FLAG_C] = s9[8];
        flags_out[PST_FLAG_AC] = s5[4];
        flags_out[PST_FLAG_OV] = (a[7] == b[7]) && (res[7] != a[7]);
      end
      PST_OP_SUB, PST_OP_SBC: begin
        // Carry set means no borrow, so the borrow in is its inverse.
        cy = (op == PST_OP_SBC) ? ~flags_in[PST_FLAG_C] : 1'b0;
        s9 = {1'b0, a} - {1'b0, b} - {8'h00, cy};
        s5 = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cy};
        res = s9[7:0];
        flags_out[PST_FLAG_C] = ~s9[8];
        flags_out[PST_FLAG_AC] = ~s5[4];
        flags_out[PST_FLAG_OV] = (a[7] != b[7]) && (res[7] != a[7]);
      end
      PST_OP_DECIMAL_ADJUST: begin
        if ((a[3:0] > PST_BCD_MAX) || flags_in[PST_FLAG_AC]) begin
          adj[3:0] = PST_BCD_ADJ;
        end
        if ((a[7:4] > PST_BCD_MAX) || flags_in[PST_FLAG_C] ||
            ((a[7:4] == PST_BCD_MAX) && (a[3:0] > PST_BCD_MAX))) begin
          adj[7:4] = PST_BCD_ADJ;
        end
        s9 = {1'b0, a} + {1'b0, adj};
        res = s9[7:0];
        flags_out[PST_FLAG_C] = flags_in[PST_FLAG_C] | s9[8];
      end
      PST_OP_AND: res = a & b;
      PST_OP_OR:  res = a | b;
      PST_OP_XOR: res = a ^ b;
      PST_OP_CPL: res = ~a;
      PST_OP_RR:  res = {a[0], a[7:1]};
      PST_OP_RL:  res = {a[6:0], a[7]};
      PST_OP_RRC: begin
        res = {flags_in[PST_FLAG_C], a[7:1]};
        flags_out[PST_FLAG_C] = a[0];
      end
      PST_OP_RLC: begin
        res = {a[6:0], flags_in[PST_FLAG_C]};
        flags_out[PST_FLAG_C] = a[7];
      end
      PST_OP_INC, PST_OP_INC_SKIP_ZERO: res = a + 8'h01;
      PST_OP_DEC, PST_OP_DEC_SKIP_ZERO: res = a - 8'h01;
      default: res = a;
    endcase
    // Zero flag follows arithmetic, logic, increment and decrement.
    if ((op <= PST_OP_CPL) || (op == PST_OP_INC) ||
        (op == PST_OP_DEC)) begin
      flags_out[PST_FLAG_Z] = (res == 8'h00);
    end
    // Skip decisions for the conditional branch operations.
    case (op)
      PST_OP_SKIP_ZERO:     skip = (a == 8'h00);
      PST_OP_SKIP_NONZERO:  skip = (a != 8'h00);
      PST_OP_INC_SKIP_ZERO: skip = (res == 8'h00);
      PST_OP_DEC_SKIP_ZERO: skip = (res == 8'h00);
      default:              skip = 1'b0;
    endcase
  end

endmodule

// ### pst_return_stack.sv
// Four level return address stack with hidden pointer and overflow.
`timescale 1ns/100ps
module pst_return_stack (
  // Clock and reset.
  input  wire logic                         clk,
  input  wire logic                         rst_b,
  // Push and pop requests.
  input  wire logic                         push,
  input  wire logic                         pop,
  input  wire logic [pst_pkg::PST_PC_W-1:0] push_pc,
  // Stack state.
  output logic [pst_pkg::PST_PC_W-1:0]      top_pc,
  output logic                              full,
  output logic                              empty,
  output logic                              overflow
);
  import pst_pkg::*;

  typedef struct packed {
    logic [PST_DEPTH-1:0][PST_PC_W-1:0] ent;
    logic [PST_SP_W-1:0]                sp;
    logic [PST_CNT_W-1:0]               cnt;
    logic                               ovf;
  } pst_stack_type;

  pst_stack_type s_q;
  pst_stack_type s_d;

  // Pointer names the next free slot; a full push lands on the oldest.
  always_comb begin
    s_d = s_q;
    s_d.ovf = 1'b0;
    if (push) begin
      s_d.ent[s_q.sp] = push_pc;
      s_d.sp = s_q.sp + 2'h1;
      if (s_q.cnt == PST_FULL_COUNT) begin
        s_d.ovf = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 3'h1;
      end
    end else if (pop && (s_q.cnt != 3'h0)) begin
      s_d.sp = s_q.sp - 2'h1;
      s_d.cnt = s_q.cnt - 3'h1;
    end
  end

  // Registers the stack; reset leaves the pointer at the top.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Entries are only visible as the restore value.
  assign top_pc = s_q.ent[s_q.sp - 2'h1];
  assign full = (s_q.cnt == PST_FULL_COUNT);
  assign empty = (s_q.cnt == 3'h0);
  assign overflow = s_q.ovf;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_STK_LIFO: assert property (
    push |=> (top_pc == $past(push_pc)))
    else $error("Pushed address is not on top of the stack.");
  AST_STK_OVERFLOW: assert property (
    (push && full) |=> (full && overflow))
    else $error("Push on a full stack did not overflow.");
  AST_STK_POP_COUNT: assert property (
    (pop && !push && !empty && !full) |=> !full ##0
    (top_pc == $past(s_q.ent[s_q.sp - 2'h2])))
    else $error("Pop did not expose the previous entry.");
  COV_STK_OVERFLOW: cover property (push && full);

endmodule

// ### pst_core.sv
// Program flow core: counter, return stack, table reads and programming.
//
// Operation
// - Four hidden return entries, pointer invisible to software.
// - Call or interrupt acknowledge pushes the program counter.
// - Either return reloads the counter from the newest entry.
// - Reset points the stack pointer at the top of the stack.
// - Interrupt with full stack stays pending until a return frees room.
// - Call with a full stack still executes and overflows.
// - Overflow loses the oldest entry and keeps the newest.
// - Operation result goes to destination and flags are updated.
// - Arithmetic, decimal adjust, logic, rotate, step and skip ops.
// - Program memory holds 1K words of 14 bits.
// - After reset execution starts at address zero.
// - Table address comes from pointer low and high bytes.
// - Table low byte to result, upper byte to table high.
// - Table high bits without program bits read as zero.
// - Table high changes only on table reads.
// - Table instructions take two instruction cycles.
// - Programming moves data both ways on one serial data line.
// - Counter steps by one; loads cost an extra cycle.
`timescale 1ns/100ps
module pst_core (
  // Clock and reset.
  input  wire logic                           SYS_CLK,
  input  wire logic                           RST_B,
  // Command from the instruction decoder.
  input  wire logic                           CMD_VALID,
  input  pst_pkg::pst_cmd_type                CMD_KIND,
  input  pst_pkg::pst_alu_op_type             CMD_ALU_OP,
  input  wire logic [pst_pkg::PST_PC_W-1:0]   CMD_ADDR,
  input  wire logic [pst_pkg::PST_DATA_W-1:0] CMD_OPERAND_A,
  input  wire logic [pst_pkg::PST_DATA_W-1:0] CMD_OPERAND_B,
  output logic                                CMD_READY,
  // Table pointer bytes.
  input  wire logic [pst_pkg::PST_DATA_W-1:0] TBL_PTR_LOW,
  input  wire logic [pst_pkg::PST_DATA_W-1:0] TBL_PTR_HIGH,
  // Results.
  output logic [pst_pkg::PST_PC_W-1:0]        PC,
  output logic [pst_pkg::PST_WORD_W-1:0]      INSTR_WORD,
  output logic [pst_pkg::PST_DATA_W-1:0]      RESULT_DATA,
  output logic                                RESULT_VALID,
  output logic [3:0]                          STATUS_FLAGS,
  output logic [pst_pkg::PST_DATA_W-1:0]      TABLE_DATA_HIGH,
  // Interrupts.
  input  wire logic                           INT_REQ,
  input  wire logic [pst_pkg::PST_PC_W-1:0]   INT_VECTOR,
  output logic                                INT_ACK,
  output logic                                STACK_FULL,
  output logic                                STACK_OVERFLOW,
  // Serial programming link.
  input  wire logic                           PROG_MODE,
  input  wire logic                           PROG_SERIAL_CLOCK,
  input  wire logic                           PROG_SERIAL_DATA_IN,
  output logic                                PROG_SERIAL_DATA_OUT,
  output logic                                PROG_SERIAL_DATA_OE_B
);
  import pst_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    pst_state_type              st;
    logic [PST_PC_W-1:0]        pc;
    logic                       int_pend;
    logic                       int_ack;
    logic [PST_DATA_W-1:0]      res;
    logic                       res_valid;
    logic [3:0]                 flags;
    logic [PST_DATA_W-1:0]      tbl_high;
    logic                       tbl_pend;
    logic [PST_WORD_W-1:0]      rd;
    logic                       clk_s;
    logic [PST_ICP_CNT_W-1:0]   icp_cnt;
    logic [PST_ICP_SH_W-1:0]    icp_sh;
    logic                       icp_rd;
    logic [PST_WORD_W-1:0]      icp_out;
    logic                       icp_oe_b;
  } pst_core_type;

  pst_core_type s_q;
  pst_core_type s_d;

  logic [PST_WORD_W-1:0]  mem [0:PST_MEM_WORDS-1];
  logic                   mem_we;
  logic [PST_PC_W-1:0]    mem_wa;
  logic [PST_WORD_W-1:0]  mem_wd;
  logic                   take_cmd;
  logic                   take_int;
  logic                   stk_push;
  logic                   stk_pop;
  logic [PST_PC_W-1:0]    stk_top;
  logic                   stk_full;
  logic                   stk_empty;
  logic [7:0]             alu_res;
  logic [3:0]             alu_flags;
  logic                   alu_skip;

  // ---------------------------------------------------------------
  // Helpers and submodules
  // ---------------------------------------------------------------

  // Forms a table address from the pointer bytes and the command kind.
  function automatic logic [PST_PC_W-1:0] tbl_addr(
    input pst_cmd_type kind,
    input logic [7:0]  lo,
    input logic [7:0]  hi
  );
    if (kind == PST_CMD_TABLE_READ_LAST_PAGE) begin
      tbl_addr = {PST_LAST_PAGE, lo};
    end else begin
      tbl_addr = {hi[1:0], lo};
    end
  endfunction

  pst_return_stack u_stack (
    .clk      (SYS_CLK),
    .rst_b    (RST_B),
    .push     (stk_push),
    .pop      (stk_pop),
    .push_pc  (s_q.pc),
    .top_pc   (stk_top),
    .full     (stk_full),
    .empty    (stk_empty),
    .overflow (STACK_OVERFLOW)
  );

  pst_alu u_alu (
    .op        (CMD_ALU_OP),
    .a         (CMD_OPERAND_A),
    .b         (CMD_OPERAND_B),
    .flags_in  (s_q.flags),
    .res       (alu_res),
    .flags_out (alu_flags),
    .skip      (alu_skip)
  );

  // ---------------------------------------------------------------
  // Handshake and stack control
  // ---------------------------------------------------------------

  // Interrupt acknowledge waits while every stack entry is in use.
  assign take_int = (s_q.st == PST_ST_RUN) && s_q.int_pend &&
                    !stk_full && !PROG_MODE;
  assign CMD_READY = (s_q.st == PST_ST_RUN) && !take_int && !PROG_MODE;
  assign take_cmd = CMD_VALID && CMD_READY;
  // A call always pushes, full or not.
  assign stk_push = take_int ||
                    (take_cmd && (CMD_KIND == PST_CMD_CALL));
  // Either return pops; an empty stack keeps its count at zero.
  assign stk_pop = take_cmd && ((CMD_KIND == PST_CMD_SUBROUTINE_RETURN) ||
                   (CMD_KIND == PST_CMD_INTERRUPT_RETURN));

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------

  // Sequences commands, table reads and the serial programming frame.
  always_comb begin
    logic [PST_PC_W-1:0] rd_addr;
    logic                rise;
    logic                fall;
    rise = PROG_SERIAL_CLOCK && !s_q.clk_s;
    fall = !PROG_SERIAL_CLOCK && s_q.clk_s;
    s_d = s_q;
    rd_addr = s_q.pc;
    mem_we = 1'b0;
    mem_wa = s_q.icp_sh[PST_ICP_SH_W-2 -: PST_PC_W];
    mem_wd = s_q.icp_sh[PST_WORD_W-1:0];
    s_d.int_ack = 1'b0;
    s_d.res_valid = 1'b0;
    // Set wins over the acknowledge clear.
    s_d.int_pend = (s_q.int_pend && !take_int) || INT_REQ;
    if (take_int) begin
      s_d.pc = INT_VECTOR;
      s_d.int_ack = 1'b1;
      s_d.st = PST_ST_SECOND;
    end else if (take_cmd) begin
      s_d.st = PST_ST_SECOND;
      case (CMD_KIND)
        PST_CMD_ALU: begin
          s_d.res = alu_res;
          s_d.res_valid = 1'b1;
          s_d.flags = alu_flags;
          s_d.pc = s_q.pc + (alu_skip ? PST_PC_SKIP : PST_PC_STEP);
          s_d.st = alu_skip ? PST_ST_SECOND : PST_ST_RUN;
        end
        PST_CMD_JUMP: s_d.pc = CMD_ADDR;
        PST_CMD_CALL: s_d.pc = CMD_ADDR;
        PST_CMD_SUBROUTINE_RETURN, PST_CMD_INTERRUPT_RETURN: begin
          s_d.pc = stk_top;
        end
        default: begin
          rd_addr = tbl_addr(CMD_KIND, TBL_PTR_LOW, TBL_PTR_HIGH);
          s_d.tbl_pend = 1'b1;
          s_d.pc = s_q.pc + PST_PC_STEP;
        end
      endcase
    end else if (s_q.st == PST_ST_SECOND) begin
      s_d.st = PST_ST_RUN;
      s_d.tbl_pend = 1'b0;
      if (s_q.tbl_pend) begin
        s_d.res = s_q.rd[PST_DATA_W-1:0];
        s_d.res_valid = 1'b1;
        // Only this path writes the table high byte.
        s_d.tbl_high = {{(PST_DATA_W-PST_HIGH_W){1'b0}},
                        s_q.rd[PST_WORD_W-1:PST_DATA_W]};
      end
    end
    // Serial programming: header of command bit and address, then data.
    // Edges compare the pin with last cycle's sample of it.
    s_d.clk_s = PROG_SERIAL_CLOCK;
    // Dropping the mode line clears the count, so a cut frame is lost.
    if (!PROG_MODE) begin
      s_d.icp_cnt = '0;
      s_d.icp_rd = 1'b0;
      s_d.icp_oe_b = 1'b1;
    end else begin
      if (rise && (s_q.icp_cnt != PST_ICP_FRAME_BITS)) begin
        s_d.icp_sh = {s_q.icp_sh[PST_ICP_SH_W-2:0], PROG_SERIAL_DATA_IN};
        s_d.icp_cnt = s_q.icp_cnt + 5'h01;
      end
      rd_addr = s_d.icp_sh[PST_PC_W-1:0];
      if (rise && (s_d.icp_cnt == PST_ICP_HDR_BITS) &&
          !s_d.icp_sh[PST_PC_W]) begin
        s_d.icp_rd = 1'b1;
        s_d.icp_oe_b = 1'b0;
      end else if (fall && s_q.icp_rd) begin
        // The host takes each bit before the fall that shifts the next out.
        s_d.icp_out = {s_q.icp_out[PST_WORD_W-2:0], 1'b0};
      end
      if (s_q.icp_cnt == PST_ICP_FRAME_BITS) begin
        s_d.icp_oe_b = 1'b1;
      end
      if (rise && (s_d.icp_cnt == PST_ICP_FRAME_BITS) &&
          s_d.icp_sh[PST_ICP_SH_W-1] && !s_q.icp_rd) begin
        mem_we = 1'b1;
        mem_wa = s_d.icp_sh[PST_ICP_SH_W-2 -: PST_PC_W];
        mem_wd = s_d.icp_sh[PST_WORD_W-1:0];
      end
    end
    s_d.rd = mem[rd_addr];
    if (PROG_MODE && rise && (s_d.icp_cnt == PST_ICP_HDR_BITS)) begin
      s_d.icp_out = mem[rd_addr];
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------

  // Registers the core state; reset enters at the reset vector.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      s_q <= '0;
      s_q.st <= PST_ST_RUN;
      s_q.pc <= PST_RESET_VECTOR;
      s_q.icp_oe_b <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Program memory array written only by the programming link.
  always_ff @(posedge SYS_CLK) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign PC = s_q.pc;
  assign INSTR_WORD = s_q.rd;
  assign RESULT_DATA = s_q.res;
  assign RESULT_VALID = s_q.res_valid;
  assign STATUS_FLAGS = s_q.flags;
  assign TABLE_DATA_HIGH = s_q.tbl_high;
  assign INT_ACK = s_q.int_ack;
  assign STACK_FULL = stk_full;
  assign PROG_SERIAL_DATA_OUT = s_q.icp_out[PST_WORD_W-1];
  assign PROG_SERIAL_DATA_OE_B = s_q.icp_oe_b;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);

  AST_CALL_TARGET: assert property (
    (take_cmd && (CMD_KIND == PST_CMD_CALL)) |=>
    ((PC == $past(CMD_ADDR)) && !CMD_READY))
    else $error("Call did not load its target with a dummy cycle.");
  AST_RETURN_PC: assert property (
    stk_pop |=> (PC == $past(stk_top)))
    else $error("Return did not restore the saved address.");
  AST_INT_HELD: assert property (
    (s_q.int_pend && stk_full) |=> !INT_ACK)
    else $error("Interrupt acknowledged with a full stack.");
  AST_INT_VECTOR: assert property (
    take_int |=> (INT_ACK && (PC == $past(INT_VECTOR)) && !stk_empty))
    else $error("Interrupt entry did not push and vector.");
  AST_TBL_TWO_CYCLES: assert property (
    (take_cmd && (CMD_KIND == PST_CMD_TABLE_READ)) |=>
    !CMD_READY ##1 RESULT_VALID)
    else $error("Table read did not finish in two cycles.");
  AST_TBL_HIGH_STABLE: assert property (
    !(s_q.tbl_pend && (s_q.st == PST_ST_SECOND)) |=> $stable(TABLE_DATA_HIGH))
    else $error("Table high changed outside a table read.");
  AST_TBL_HIGH_ZERO: assert property (
    TABLE_DATA_HIGH[PST_DATA_W-1:PST_HIGH_W] == 2'h0)
    else $error("Unused table high bits are not zero.");
  AST_ALU_STEP: assert property (
    (take_cmd && (CMD_KIND == PST_CMD_ALU) && !alu_skip) |=>
    (PC == $past(PC) + PST_PC_STEP))
    else $error("Counter did not step by one.");

  // Skip, overflow, interrupt entry and programming frame checks.
  AST_SKIP_DUMMY: assert property (
    (take_cmd && (CMD_KIND == PST_CMD_ALU) && alu_skip) |=>
    ((PC == $past(PC) + PST_PC_SKIP) && !CMD_READY))
    else $error("Skip did not jump two with a dummy cycle.");
  AST_CALL_OVERFLOW: assert property (
    (take_cmd && (CMD_KIND == PST_CMD_CALL) && stk_full) |=>
    STACK_OVERFLOW)
    else $error("Call on a full stack did not overflow.");
  AST_INT_DUMMY: assert property (
    take_int |=> !CMD_READY)
    else $error("Interrupt entry did not insert a dummy cycle.");
  AST_PROG_RELEASE: assert property (
    (s_q.icp_cnt == PST_ICP_FRAME_BITS) |=> PROG_SERIAL_DATA_OE_B)
    else $error("Data line still driven after the frame.");

  COV_CALL: cover property (take_cmd && (CMD_KIND == PST_CMD_CALL));
  COV_INT_FULL: cover property (s_q.int_pend && stk_full ##1 stk_pop);
  COV_TBL_LAST: cover property (
    take_cmd && (CMD_KIND == PST_CMD_TABLE_READ_LAST_PAGE));
  COV_PROG_READ: cover property (s_q.icp_rd && !PROG_SERIAL_DATA_OE_B);

endmodule

// ### pst_prog_model.sv
// Serial programmer model that loads program words into the block.
`timescale 1ns/100ps
module pst_prog_model (
  // Clock.
  input  wire logic clk,
  // Shared data line as the block sees it.
  input  wire logic sd_in,
  // Programming lines.
  output logic      mode,
  output logic      sck,
  output logic      sd
);
  logic [24:0] frame;
  // Lines idle: clock stands still between frames.
  initial begin
    mode = 1'b0;
    sck  = 1'b0;
    sd   = 1'b1;
  end
  // Sends one frame MSB first, four system cycles per bit; a read frame
  // takes each reply bit just before the fall that shifts the next out.
  task automatic send(input logic wr, input logic [9:0] addr,
                      input logic [13:0] word, output logic [13:0] got);
    frame = {wr, addr, word};
    got = 14'h0000;
    @(negedge clk) mode = 1'b1;
    for (int i = 24; i >= 0; i--) begin
      @(negedge clk) sck = 1'b0;
      if (i < 14) got[i] = sd_in;
      @(negedge clk) sck = 1'b0;
      sd = frame[i];
      repeat (2) @(negedge clk) sck = 1'b1;
    end
    repeat (3) @(negedge clk) sck = 1'b0;
    mode = 1'b0;
    sd = ~sd;
  endtask
endmodule

// ### pst_core_test.sv
// Self-checking testbench for the program flow core.
`timescale 1ns/100ps
module pst_core_test;
  import pst_pkg::*;
  logic SYS_CLK = 1'b0, RST_B = 1'b0, CMD_VALID = 1'b0, INT_REQ = 1'b0;
  pst_cmd_type CMD_KIND = PST_CMD_ALU;
  pst_alu_op_type CMD_ALU_OP = PST_OP_ADD;
  logic [9:0] CMD_ADDR = 10'h000, INT_VECTOR = 10'h004, pc_b[5];
  logic [7:0] op_a = 8'h00, op_b = 8'h00, tp_lo = 8'h00, tp_hi = 8'h00;
  logic [9:0] PC;
  logic [13:0] INSTR_WORD;
  logic [7:0] RESULT_DATA, TABLE_DATA_HIGH;
  logic [3:0] STATUS_FLAGS;
  logic CMD_READY, RESULT_VALID, INT_ACK, STACK_FULL, STACK_OVERFLOW;
  logic mode, sck, sd, dout, oe_b, ovf1;
  logic [13:0] got;
  int error_cnt = 0, samples_checked = 0, n;
  // Free running 40 MHz clock.
  always #12.5 SYS_CLK = ~SYS_CLK;
  pst_prog_model i_pst_prog_model (.clk(SYS_CLK), .sd_in(oe_b ? sd : dout),
    .mode(mode), .sck(sck), .sd(sd));
  pst_core i_pst_core (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .CMD_VALID(CMD_VALID),
    .CMD_KIND(CMD_KIND), .CMD_ALU_OP(CMD_ALU_OP), .CMD_ADDR(CMD_ADDR),
    .CMD_OPERAND_A(op_a), .CMD_OPERAND_B(op_b), .CMD_READY(CMD_READY),
    .TBL_PTR_LOW(tp_lo), .TBL_PTR_HIGH(tp_hi), .PC(PC), .INSTR_WORD(INSTR_WORD),
    .RESULT_DATA(RESULT_DATA), .RESULT_VALID(RESULT_VALID),
    .STATUS_FLAGS(STATUS_FLAGS), .TABLE_DATA_HIGH(TABLE_DATA_HIGH),
    .INT_REQ(INT_REQ), .INT_VECTOR(INT_VECTOR), .INT_ACK(INT_ACK),
    .STACK_FULL(STACK_FULL), .STACK_OVERFLOW(STACK_OVERFLOW),
    .PROG_MODE(mode), .PROG_SERIAL_CLOCK(sck),
    .PROG_SERIAL_DATA_IN(oe_b ? sd : dout), .PROG_SERIAL_DATA_OUT(dout),
    .PROG_SERIAL_DATA_OE_B(oe_b));
  // Prints the verdict and ends the run.
  task automatic tally_and_finish;
    $display("checked %0d, wrong %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Compares one value with its expectation.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Holds reset low for 20 cycles.
  task automatic do_reset;
    RST_B = 1'b0;
    repeat (20) @(negedge SYS_CLK);
    RST_B = 1'b1;
    check(PC, 16'h0000);
    check(STACK_FULL, 16'h0000);
  endtask
  // Offers one command, waits for the take, samples the cycle after.
  task automatic issue(input pst_cmd_type k, input logic [9:0] ad);
    n = 0;
    while (CMD_READY !== 1'b1 && n < 40) begin
      @(negedge SYS_CLK);
      n++;
    end
    if (CMD_READY !== 1'b1) begin
      error_cnt++;
      tally_and_finish();
    end
    CMD_VALID = 1'b1;
    CMD_KIND = k;
    CMD_ADDR = ad;
    @(negedge SYS_CLK) CMD_VALID = 1'b0;
    ovf1 = STACK_OVERFLOW;
  endtask
  // Table reads through both pointer forms, then an add.
  task automatic test_table;
    i_pst_prog_model.send(1'b1, 10'h105, 14'h3f81, got);
    i_pst_prog_model.send(1'b1, 10'h306, 14'h2c5a, got);
    i_pst_prog_model.send(1'b0, 10'h105, 14'h0000, got);
    check(got, 16'h3f81);
    check(oe_b, 16'h0001);
    tp_hi = 8'h01;
    tp_lo = 8'h05;
    INT_REQ = 1'b0;
    issue(PST_CMD_TABLE_READ, 10'h000);
    check(RESULT_VALID, 16'h0000);
    check(INSTR_WORD, 16'h3f81);
    @(negedge SYS_CLK);
    check({RESULT_VALID, RESULT_DATA}, 16'h0181);
    check(TABLE_DATA_HIGH, 16'h003f);
    tp_lo = 8'h06;
    issue(PST_CMD_TABLE_READ_LAST_PAGE, 10'h000);
    @(negedge SYS_CLK);
    check({RESULT_DATA, TABLE_DATA_HIGH}, 16'h5a2c);
    op_a = 8'h70;
    op_b = 8'h95;
    issue(PST_CMD_ALU, 10'h000);
    check({RESULT_VALID, RESULT_DATA}, 16'h0105);
    check(STATUS_FLAGS[PST_FLAG_C], 16'h0001);
    check(TABLE_DATA_HIGH, 16'h002c);
    CMD_ALU_OP = PST_OP_SKIP_ZERO;
    op_a = 8'h00;
    pc_b[0] = PC;
    issue(PST_CMD_ALU, 10'h000);
    check(PC, 16'(pc_b[0]) + 16'h0002);
    check(CMD_READY, 16'h0000);
    $display("table and add test done");
  endtask
  // Five nested calls overflow; returns give the newest four back.
  task automatic test_stack;
    do_reset();
    for (int i = 0; i < 5; i++) begin
      pc_b[i] = PC;
      issue(PST_CMD_CALL, 10'h040 + 10'(i));
      check(PC, 16'h0040 + 16'(i));
      check(ovf1, 16'(i == 4));
      if (i == 3) check(STACK_FULL, 16'h0001);
    end
    for (int i = 4; i > 0; i--) begin
      issue(i[0] ? PST_CMD_INTERRUPT_RETURN : PST_CMD_SUBROUTINE_RETURN, 10'h0);
      check(PC, 16'(pc_b[i]));
    end
    $display("stack test done");
  endtask
  // Interrupt waits while the stack is full and runs after a return.
  task automatic test_int_full;
    do_reset();
    for (int i = 0; i < 4; i++) issue(PST_CMD_CALL, 10'h080 + 10'(i));
    @(negedge SYS_CLK) INT_REQ = 1'b1;
    @(negedge SYS_CLK) INT_REQ = 1'b0;
    repeat (6) begin
      @(negedge SYS_CLK);
      check(INT_ACK, 16'h0000);
    end
    issue(PST_CMD_SUBROUTINE_RETURN, 10'h000);
    n = 0;
    while (INT_ACK !== 1'b1 && n < 10) begin
      @(negedge SYS_CLK);
      n++;
    end
    if (INT_ACK !== 1'b1) begin
      error_cnt++;
      tally_and_finish();
    end
    check(PC, 16'h0004);
    $display("interrupt test done");
  endtask
  // Main sequence.
  initial begin
    do_reset();
    test_table();
    test_stack();
    test_int_full();
    tally_and_finish();
  end
endmodule
